// File: bench/lpm_cpu_model.sv
// cpu core and peripheral stand-in: wait/stop pulses and a wake request
// assumes the sequencer samples everything on the rising edge of sys_clk_in
`timescale 1ns/10ps
module lpm_cpu_model (
  input  wire logic sys_clk_in,
  input  wire logic stack_start_in,
  output logic      wait_exec_out,
  output logic      stop_exec_out,
  output logic      irq_req_out
);
  initial begin
    wait_exec_out = 1'b0;
    stop_exec_out = 1'b0;
    irq_req_out   = 1'b0;
  end

  // ----------------------------------------
  // instruction and wake requests
  // ----------------------------------------
  // caller sits just after an edge; returns one edge later
  task automatic exec_op(input logic is_stop);
    wait_exec_out = ~is_stop;
    stop_exec_out = is_stop;
    @(posedge sys_clk_in);
    #1;
    wait_exec_out = 1'b0;
    stop_exec_out = 1'b0;
  endtask : exec_op

  // slow peripherals raise their request some cycles late
  task automatic raise_irq(input int dly);
    repeat (dly) begin
      @(posedge sys_clk_in);
      #1;
    end
    irq_req_out = 1'b1;
  endtask : raise_irq

  // request is withdrawn once stacking has begun
  always @(posedge sys_clk_in) begin
    if (stack_start_in === 1'b1) begin
      #1 irq_req_out = 1'b0;
    end
  end
endmodule : lpm_cpu_model

// File: bench/tb.sv
// self-checking bench of the low-power sequencer and its status registers
// assumes the cpu stand-in model and a single 50 MHz clock
`timescale 1ns/10ps
`include "lpm_defs.svh"
module tb;
  import lpm_pkg::*;
  logic        sys_clk_in, rst_n_in, clk_en_in, bus_rd_in, bus_wr_in;
  logic [15:0] bus_addr_in;
  logic [7:0]  bus_wdata_in, bus_rdata_out, vec_hi, vec_lo, cause_exp [5];
  logic        wait_exec, stop_exec, irq_req, break_req_in, break_state_in;
  logic        emulation_mode_in, wdog_opt, short_rec, rst_pin_n_in, irq_pin_in;
  logic        wdog_timeout_in, low_voltage_in, bad_opcode_in, bad_address_in;
  logic        opcode_fetch_in, cpu_clk_en, periph_clk_en, main_clk_en, xtal_clk_en;
  logic        stack_start, int_mask_clear, wdog_enable, clear_allow, rd_seen, sys_reset;
  lpm_state_t  mode_out;
  logic [7:0]  exp_q [$];
  int          fails, total_checks, cycles, seed, n;

  lpm_top dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .bus_addr_in(bus_addr_in), .bus_rd_in(bus_rd_in), .bus_wr_in(bus_wr_in),
    .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .wait_exec_in(wait_exec),
    .stop_exec_in(stop_exec), .irq_req_in(irq_req), .break_req_in(break_req_in),
    .break_state_in(break_state_in), .emulation_mode_in(emulation_mode_in),
    .watchdog_disable_option_in(wdog_opt), .short_stop_recovery_in(short_rec),
    .rst_pin_n_in(rst_pin_n_in), .wdog_timeout_in(wdog_timeout_in),
    .low_voltage_in(low_voltage_in), .bad_opcode_in(bad_opcode_in),
    .bad_address_in(bad_address_in), .opcode_fetch_in(opcode_fetch_in),
    .reset_vector_hi_in(vec_hi), .reset_vector_lo_in(vec_lo), .irq_pin_in(irq_pin_in),
    .cpu_clk_en_out(cpu_clk_en), .periph_clk_en_out(periph_clk_en),
    .main_clk_en_out(main_clk_en), .xtal_clk_en_out(xtal_clk_en),
    .stack_start_out(stack_start), .int_mask_clear_out(int_mask_clear),
    .wdog_enable_out(wdog_enable), .flag_clear_allow_out(clear_allow),
    .sys_reset_out(sys_reset), .mode_out(mode_out));

  lpm_cpu_model cpu_u (.sys_clk_in(sys_clk_in), .stack_start_in(stack_start),
    .wait_exec_out(wait_exec), .stop_exec_out(stop_exec), .irq_req_out(irq_req));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step();
    @(posedge sys_clk_in);
    #1;
  endtask : step

  // idle cycle after each access keeps strobes from re-rising in one step
  task automatic reg_rd(input logic [15:0] addr, input logic [7:0] exp);
    bus_addr_in = addr;
    bus_rd_in = 1'b1;
    exp_q.push_back(exp);
    step();
    bus_rd_in = 1'b0;
    step();
  endtask : reg_rd

  task automatic reg_wr(input logic [15:0] addr, input logic [7:0] data);
    bus_addr_in = addr;
    bus_wdata_in = data;
    bus_wr_in = 1'b1;
    step();
    bus_wr_in = 1'b0;
    step();
  endtask : reg_wr

  task automatic fire_cause(input int idx);
    case (idx)
      0: wdog_timeout_in = 1'b1;
      1: low_voltage_in = 1'b1;
      2: bad_opcode_in = 1'b1;
      3: opcode_fetch_in = 1'b1;
      default: ;
    endcase
    bad_address_in = (idx >= 3);
    step();
    {wdog_timeout_in, low_voltage_in, bad_opcode_in, bad_address_in} = 4'h0;
    opcode_fetch_in = 1'b0;
  endtask : fire_cause

  task automatic ck_mode(input lpm_state_t m);
    check(16'(mode_out), 16'(m));
  endtask : ck_mode

  task automatic run_stop(input logic short_sel, input int limit);
    short_rec = short_sel;
    step();
    cpu_u.exec_op(1'b1);
    ck_mode(LPM_STOP);
    check(16'({cpu_clk_en, main_clk_en, xtal_clk_en, periph_clk_en}), 16'h0);
    cpu_u.raise_irq(3);
    step();
    ck_mode(LPM_RECOVER);
    check(16'({xtal_clk_en, main_clk_en}), 16'h2);
    // counter steps taken after the entry edge, one per cycle in recovery
    n = 0;
    while (mode_out === LPM_RECOVER && n < 5000) begin
      step();
      n += (mode_out === LPM_RECOVER);
    end
    check(16'(n), 16'(limit));
    check(16'({stack_start, cpu_clk_en, main_clk_en}), 16'h7);
  endtask : run_stop

  // ----------------------------------------
  // clock, result watcher, hang guard
  // ----------------------------------------
  initial sys_clk_in = 1'b0;
  always #10 sys_clk_in = ~sys_clk_in;

  always @(posedge sys_clk_in) begin
    if (rd_seen === 1'b1) begin
      check(16'(bus_rdata_out), 16'(exp_q.pop_front()));
    end
    rd_seen <= bus_rd_in;
    cycles++;
    if (cycles == 12000) begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h7700a16a;
    {rst_n_in, bus_rd_in, bus_wr_in, rd_seen, break_req_in, break_state_in} = 6'h0;
    {emulation_mode_in, wdog_opt, short_rec, irq_pin_in} = 4'h0;
    {wdog_timeout_in, low_voltage_in, bad_opcode_in, bad_address_in} = 4'h0;
    {clk_en_in, rst_pin_n_in, opcode_fetch_in} = 3'b110;
    bus_addr_in = 16'h0000;
    bus_wdata_in = 8'h00;
    vec_hi = 8'($random(seed));
    vec_lo = 8'h00;
    cause_exp = '{8'(1 << `LPM_BIT_WDOG), 8'(1 << `LPM_BIT_LVI),
      8'(1 << `LPM_BIT_OPCODE), 8'(1 << `LPM_BIT_ADDR), 8'h00};
    repeat (2) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (4) step();
    // status after power-on, then cleared by reading
    reg_rd(`LPM_ADDR_RESET_STATUS, 8'h80);
    reg_rd(`LPM_ADDR_RESET_STATUS, 8'h00);
    reg_rd(`LPM_ADDR_BREAK_CTRL, 8'h00);
    reg_wr(16'hfe02, 8'($random(seed)));
    reg_rd(16'hfe02, 8'h00);
    check(16'(wdog_enable), 16'h1);
    // each reset cause sets only its own flag
    for (int i = 0; i < 5; i++) begin
      fire_cause(i);
      step();
      reg_rd(`LPM_ADDR_RESET_STATUS, cause_exp[i]);
    end
    rst_pin_n_in = 1'b0;
    repeat (4) step();
    rst_pin_n_in = 1'b1;
    step();
    reg_rd(`LPM_ADDR_RESET_STATUS, 8'(1 << `LPM_BIT_PIN));
    // clear-enable control register and protection in break
    for (int i = 0; i < 3; i++) begin
      bus_wdata_in = 8'($random(seed));
      reg_wr(`LPM_ADDR_BREAK_CTRL, bus_wdata_in);
      reg_rd(`LPM_ADDR_BREAK_CTRL, {bus_wdata_in[`LPM_BIT_CLEAR_EN], 7'h00});
    end
    reg_wr(`LPM_ADDR_BREAK_CTRL, 8'h00);
    break_state_in = 1'b1;
    fire_cause(0);
    step();
    check(16'(clear_allow), 16'h0);
    reg_rd(`LPM_ADDR_RESET_STATUS, cause_exp[0]);
    reg_rd(`LPM_ADDR_RESET_STATUS, cause_exp[0]);
    reg_wr(`LPM_ADDR_BREAK_CTRL, 8'h80);
    check(16'(clear_allow), 16'h1);
    reg_rd(`LPM_ADDR_RESET_STATUS, cause_exp[0]);
    reg_rd(`LPM_ADDR_RESET_STATUS, 8'h00);
    break_state_in = 1'b0;
    cpu_u.exec_op(1'b0);
    ck_mode(LPM_WAIT);
    check(16'({cpu_clk_en, periph_clk_en, int_mask_clear, wdog_enable}), 16'h7);
    cpu_u.raise_irq(0);
    step();
    ck_mode(LPM_RUN);
    check(16'({stack_start, cpu_clk_en}), 16'h3);
    step();
    check(16'(stack_start), 16'h0);
    // break exit with and without emulation
    for (int e = 1; e >= 0; e--) begin
      emulation_mode_in = e[0];
      cpu_u.exec_op(1'b0);
      break_req_in = 1'b1;
      step();
      break_req_in = 1'b0;
      step();
      ck_mode(e ? LPM_RUN : LPM_WAIT);
      if (e == 0) begin
        cpu_u.raise_irq(0);
        step();
      end
      reg_rd(`LPM_ADDR_BREAK_STATUS, 8'(e << `LPM_BIT_BRK_WAIT));
      reg_wr(`LPM_ADDR_BREAK_STATUS, 8'h00);
      reg_rd(`LPM_ADDR_BREAK_STATUS, 8'h00);
    end
    // reset causes end wait and stop without stacking
    for (int s = 0; s < 2; s++) begin
      cpu_u.exec_op(s[0]);
      fire_cause(1);
      check(16'({sys_reset, mode_out}), 16'(3'h4 | 3'(LPM_RUN)));
      step();
      check(16'(sys_reset), 16'h0);
      ck_mode(LPM_RUN);
      check(16'(stack_start), 16'h0);
      reg_rd(`LPM_ADDR_RESET_STATUS, cause_exp[1]);
    end
    run_stop(1'b1, 32);
    run_stop(1'b0, 4096);
    wdog_opt = 1'b1;
    repeat (2) step();
    check(16'(wdog_enable), 16'h0);
    // low clock enable must freeze the registered option
    clk_en_in = 1'b0;
    wdog_opt = 1'b0;
    repeat (2) step();
    check(16'(wdog_enable), 16'h0);
    clk_en_in = 1'b1;
    step();
    check(16'(wdog_enable), 16'h1);
    // monitor entry with erased vector and irq pin high
    rst_n_in = 1'b0;
    {vec_hi, vec_lo, irq_pin_in} = {`LPM_ERASED_BYTE, `LPM_ERASED_BYTE, 1'b1};
    repeat (2) step();
    rst_n_in = 1'b1;
    repeat (6) step();
    reg_rd(`LPM_ADDR_RESET_STATUS, 8'h80 | 8'(1 << `LPM_BIT_MONITOR));
    finish_test();
  end
endmodule : tb

// File: core/lpm_rec_counter.sv
// system counter that times stop recovery
// assumes clear and run come from the sequencer on the same clock
`timescale 1ns/10ps
`include "lpm_defs.svh"
module lpm_rec_counter (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic clk_en_in,
  lpm_cnt_if.cnt    cnt_if
);
  import lpm_pkg::*;

  logic [`LPM_REC_CNT_W-1:0] limit;

  assign limit = cnt_if.short_sel ? `LPM_REC_SHORT_CYC : `LPM_REC_LONG_CYC;
  assign cnt_if.done = (cnt_if.count == limit);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_if.count <= '0;
    end else if (clk_en_in) begin
      if (cnt_if.clear) begin
        cnt_if.count <= '0;
      end else if (cnt_if.run && !cnt_if.done) begin
        cnt_if.count <= cnt_if.count + `LPM_REC_CNT_W'(1);
      end
    end
  end

  a_count_held_zero: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && cnt_if.clear) |=> (cnt_if.count == '0))
    else $error("recovery counter not cleared while held");
endmodule : lpm_rec_counter

// File: core/lpm_top.sv
// low-power mode sequencer with break and reset status registers
// assumes cpu strobes and reset source pulses are on sys_clk_in;
// the reset pin and irq pin level arrive asynchronously
`timescale 1ns/10ps
`include "lpm_defs.svh"
module lpm_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [15:0] bus_addr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_wr_in,
  input  wire logic [7:0]  bus_wdata_in,
  output logic      [7:0]  bus_rdata_out,
  input  wire logic        wait_exec_in,
  input  wire logic        stop_exec_in,
  input  wire logic        irq_req_in,
  input  wire logic        break_req_in,
  input  wire logic        break_state_in,
  input  wire logic        emulation_mode_in,
  input  wire logic        watchdog_disable_option_in,
  input  wire logic        short_stop_recovery_in,
  input  wire logic        rst_pin_n_in,
  input  wire logic        wdog_timeout_in,
  input  wire logic        low_voltage_in,
  input  wire logic        bad_opcode_in,
  input  wire logic        bad_address_in,
  input  wire logic        opcode_fetch_in,
  input  wire logic [7:0]  reset_vector_hi_in,
  input  wire logic [7:0]  reset_vector_lo_in,
  input  wire logic        irq_pin_in,
  output logic             cpu_clk_en_out,
  output logic             periph_clk_en_out,
  output logic             main_clk_en_out,
  output logic             xtal_clk_en_out,
  output logic             stack_start_out,
  output logic             int_mask_clear_out,
  output logic             wdog_enable_out,
  output logic             flag_clear_allow_out,
  output logic             sys_reset_out,
  output lpm_pkg::lpm_state_t mode_out
);
  import lpm_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  lpm_cnt_if  cnt_if ();
  lpm_state_t state;
  lpm_state_t next_state;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic       pin_prev;
  logic       pin_evt;
  logic       mon_evt;
  logic       any_reset;
  logic [1:0] mon_wait;
  logic       mon_pend;
  logic       clear_ok;
  logic       brk_wait_flag;
  logic       clear_enable;
  logic [7:0] reset_status;
  logic [7:0] next_reset_status;
  logic       hit_bsr;
  logic       hit_reset_cause_status;
  logic       hit_break_flag_control;
  logic       wake_stack;
  logic       brk_exit;
  logic [`LPM_REC_CNT_W-1:0] rec_len;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1    <= 2'h1;
      sync2    <= 2'h1;
      pin_prev <= 1'b1;
    end else if (clk_en_in) begin
      sync1    <= {irq_pin_in, rst_pin_n_in};
      sync2    <= sync1;
      pin_prev <= sync2[0];
    end
  end

  assign pin_evt = pin_prev && !sync2[0];

  // ----------------------------------------
  // monitor entry check after power-on
  // ----------------------------------------
  // wait for the irq synchroniser to settle before trusting its level
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mon_wait <= 2'h0;
      mon_pend <= 1'b1;
    end else if (clk_en_in) begin
      if (mon_wait != `LPM_MON_SETTLE_CYC) begin
        mon_wait <= mon_wait + 2'h1;
      end else begin
        mon_pend <= 1'b0;
      end
    end
  end

  assign mon_evt = mon_pend && (mon_wait == `LPM_MON_SETTLE_CYC) && sync2[1]
                   && (reset_vector_hi_in == `LPM_ERASED_BYTE)
                   && (reset_vector_lo_in == `LPM_ERASED_BYTE);

  // address reset on opcode fetch only
  assign any_reset = pin_evt || wdog_timeout_in || low_voltage_in || bad_opcode_in
                     || (bad_address_in && opcode_fetch_in) || mon_evt;

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  // wait wake on interrupt
  assign wake_stack = (state == LPM_WAIT) && irq_req_in;
  assign brk_exit   = (state == LPM_WAIT) && break_req_in && emulation_mode_in;

  always_comb begin
    next_state = state;
    case (state)
      LPM_RUN: begin
        if (stop_exec_in) begin
          next_state = LPM_STOP;
        end else if (wait_exec_in) begin
          next_state = LPM_WAIT;
        end
      end
      LPM_WAIT: begin
        if (wake_stack || brk_exit) begin
          next_state = LPM_RUN;
        end
      end
      LPM_STOP: begin
        if (irq_req_in) begin
          next_state = LPM_RECOVER;
        end
      end
      LPM_RECOVER: begin
        if (cnt_if.done) begin
          next_state = LPM_RUN;
        end
      end
      default: begin
        next_state = LPM_RUN;
      end
    endcase
    if (any_reset) begin
      next_state = LPM_RUN;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= LPM_RUN;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // recovery counter control
  // ----------------------------------------
  // cleared until recovery starts
  assign cnt_if.clear     = (state != LPM_RECOVER);
  assign cnt_if.run       = (state == LPM_RECOVER);
  assign cnt_if.short_sel = short_stop_recovery_in;

  lpm_rec_counter u_rec_counter (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .cnt_if     (cnt_if.cnt)
  );

  // ----------------------------------------
  // clock gates and cpu strobes
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_clk_en_out     <= 1'b1;
      periph_clk_en_out  <= 1'b1;
      main_clk_en_out    <= 1'b1;
      xtal_clk_en_out    <= 1'b1;
      stack_start_out    <= 1'b0;
      int_mask_clear_out <= 1'b0;
      sys_reset_out      <= 1'b0;
      mode_out           <= LPM_RUN;
    end else if (clk_en_in) begin
      cpu_clk_en_out     <= (next_state == LPM_RUN);
      periph_clk_en_out  <= (next_state != LPM_STOP) && (next_state != LPM_RECOVER);
      main_clk_en_out    <= (next_state != LPM_STOP) && (next_state != LPM_RECOVER);
      // oscillator restarts at recovery so the counter sees crystal cycles
      xtal_clk_en_out    <= (next_state != LPM_STOP);
      stack_start_out    <= !any_reset && (wake_stack
                            || ((state == LPM_RECOVER) && cnt_if.done));
      int_mask_clear_out <= (state == LPM_RUN) && (wait_exec_in || stop_exec_in)
                            && !any_reset;
      sys_reset_out      <= any_reset;
      mode_out           <= next_state;
    end
  end

  // ----------------------------------------
  // break protection
  // ----------------------------------------
  // clears gated during break
  assign clear_ok = !break_state_in || clear_enable;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_enable_out      <= 1'b0;
      flag_clear_allow_out <= 1'b1;
    end else if (clk_en_in) begin
      wdog_enable_out      <= !watchdog_disable_option_in;
      flag_clear_allow_out <= !break_state_in || clear_enable;
    end
  end

  // ----------------------------------------
  // register decode and storage
  // ----------------------------------------
  // fixed addresses
  assign hit_bsr  = (bus_addr_in == `LPM_ADDR_BREAK_STATUS);
  assign hit_reset_cause_status = (bus_addr_in == `LPM_ADDR_RESET_STATUS);
  assign hit_break_flag_control = (bus_addr_in == `LPM_ADDR_BREAK_CTRL);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clear_enable <= `LPM_RST_BREAK_CTRL;
    end else if (clk_en_in && bus_wr_in && hit_break_flag_control) begin
      clear_enable <= bus_wdata_in[`LPM_BIT_CLEAR_EN];
    end
  end

  // set on break exit, set wins
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brk_wait_flag <= 1'b0;
    end else if (clk_en_in) begin
      if (brk_exit && !any_reset) begin
        brk_wait_flag <= 1'b1;
      end else if (bus_wr_in && hit_bsr && clear_ok && !bus_wdata_in[`LPM_BIT_BRK_WAIT]) begin
        brk_wait_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    next_reset_status = reset_status;
    if (bus_rd_in && hit_reset_cause_status && clear_ok) begin
      next_reset_status = 8'h00;
    end
    if (pin_evt) begin
      next_reset_status[`LPM_BIT_PIN] = 1'b1;
    end
    if (wdog_timeout_in) begin
      next_reset_status[`LPM_BIT_WDOG] = 1'b1;
    end
    if (low_voltage_in) begin
      next_reset_status[`LPM_BIT_LVI] = 1'b1;
    end
    if (bad_opcode_in) begin
      next_reset_status[`LPM_BIT_OPCODE] = 1'b1;
    end
    if (bad_address_in && opcode_fetch_in) begin
      next_reset_status[`LPM_BIT_ADDR] = 1'b1;
    end
    if (mon_evt) begin
      next_reset_status[`LPM_BIT_MONITOR] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reset_status <= `LPM_RST_RESET_STATUS;
    end else if (clk_en_in) begin
      reset_status <= next_reset_status;
    end
  end

  // unmapped addresses and reserved bits read zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_rdata_out <= 8'h00;
    end else if (clk_en_in && bus_rd_in) begin
      bus_rdata_out <= 8'h00;
      if (hit_bsr) begin
        bus_rdata_out[`LPM_BIT_BRK_WAIT] <= brk_wait_flag;
      end else if (hit_reset_cause_status) begin
        bus_rdata_out <= reset_status;
      end else if (hit_break_flag_control) begin
        bus_rdata_out[`LPM_BIT_CLEAR_EN] <= clear_enable;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rec_len <= '0;
    end else if (clk_en_in) begin
      rec_len <= (state == LPM_RECOVER) ? rec_len + `LPM_REC_CNT_W'(1) : '0;
    end
  end

  a_wait_cpu_gated: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == LPM_WAIT) |-> (!cpu_clk_en_out && periph_clk_en_out))
    else $error("wait mode clock gating wrong");

  a_wait_irq_stack: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && wake_stack && !any_reset) |=> (stack_start_out && state == LPM_RUN))
    else $error("interrupt did not wake from wait");

  a_reset_exits_low: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && any_reset && state != LPM_RUN) |=> (state == LPM_RUN && !stack_start_out))
    else $error("reset did not leave low-power mode");

  a_break_wait_flag: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && brk_exit && !any_reset) |=> (brk_wait_flag && state == LPM_RUN))
    else $error("break exit from wait not flagged");

  a_stop_clocks_off: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == LPM_STOP) |-> (!main_clk_en_out && !xtal_clk_en_out && !cpu_clk_en_out))
    else $error("clocks running in stop");

  a_recovery_length: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == LPM_RECOVER && cnt_if.done) |->
      (rec_len == (short_stop_recovery_in ? `LPM_REC_SHORT_CYC : `LPM_REC_LONG_CYC)))
    else $error("stop recovery length wrong");

  a_no_early_stack: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == LPM_STOP || state == LPM_RECOVER) |-> !stack_start_out)
    else $error("stacking before recovery ended");

  a_status_read_clear: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && bus_rd_in && hit_reset_cause_status && clear_ok && !any_reset) |=> (reset_status == 8'h00))
    else $error("reset status not cleared by read");

  a_break_protects: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && break_state_in && !clear_enable && !any_reset)
      |=> (reset_status == $past(reset_status) && brk_wait_flag == $past(brk_wait_flag)))
    else $error("status cleared during protected break");

  a_mask_clear_entry: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (clk_en_in && state == LPM_RUN && wait_exec_in && !any_reset) |=> int_mask_clear_out)
    else $error("interrupt mask not cleared on entry");
endmodule : lpm_top

// File: include/lpm_cnt_if.sv
// carrier between the sequencer and its recovery counter
// assumes both ends run on the same clock
`timescale 1ns/10ps
`include "lpm_defs.svh"
interface lpm_cnt_if;
  logic                      clear;
  logic                      run;
  logic                      short_sel;
  logic                      done;
  logic [`LPM_REC_CNT_W-1:0] count;
  modport ctl (output clear, output run, output short_sel, input done, input count);
  modport cnt (input clear, input run, input short_sel, output done, output count);
endinterface : lpm_cnt_if

// File: include/lpm_defs.svh
// constants of the low-power mode sequencer and its status registers
// assumes an 8-bit cpu register port and a 50 MHz crystal-derived clock
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LPM_ADDR_BREAK_STATUS 16'hfe00
`define LPM_ADDR_RESET_STATUS 16'hfe01
`define LPM_ADDR_BREAK_CTRL   16'hfe03

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define LPM_BIT_BRK_WAIT      1
`define LPM_BIT_POR           7
`define LPM_BIT_PIN           6
`define LPM_BIT_WDOG          5
`define LPM_BIT_OPCODE        4
`define LPM_BIT_ADDR          3
`define LPM_BIT_MONITOR       2
`define LPM_BIT_LVI           1
`define LPM_BIT_CLEAR_EN      7
`define LPM_RST_RESET_STATUS  8'h80
`define LPM_RST_BREAK_CTRL    1'b0
`define LPM_ERASED_BYTE       8'hff

// ----------------------------------------
// timing in crystal clock cycles
// ----------------------------------------
`define LPM_REC_CNT_W         13
`define LPM_REC_LONG_CYC      13'h1000
`define LPM_REC_SHORT_CYC     13'h0020
`define LPM_MON_SETTLE_CYC    2'h3

`endif

// File: include/lpm_pkg.sv
// types of the low-power mode sequencer
// assumes nothing beyond the constants header
package lpm_pkg;
  typedef enum logic [1:0] {
    LPM_RUN,
    LPM_WAIT,
    LPM_STOP,
    LPM_RECOVER
  } lpm_state_t;
endpackage : lpm_pkg
